// ### rsr_defs.svh
// constants for the receiver status read-out block
// What this block does
// - Bus address 0xE9 selects the status and channel-status read-out, which then appears on the serial data output.
// - In the 0xE9 read-out, position 0 is the channel-status update flag, position 1 the error pin and position 7 is zero.
// - Positions 2 and 3 of the 0xE9 read-out carry the two delay-state pins.
// - Positions 4 to 6 of the 0xE9 read-out carry the three rate-code pins.
// - Status positions 0 to 6 take the live pin levels at the moment the read starts.
// - Channel-status bits 0 to 47 sit in positions 8 to 55, least significant bit first.
// - The 48 channel-status bits are frozen when chip enable rises to start the read and stay fixed for that read.
// - Channel-status groups are application, control, category, source, channel, rate, accuracy and word length.
// - Bus address 0xEA selects the Pc read-out, sent most significant bit first with bit 15 in position 0.
// - Positions 16 to 55 of the 0xEA read-out are zero.
// - The Pc word holds stream number, type-dependent info, error, reserved and data type fields.
`ifndef RSR_DEFS_SVH
`define RSR_DEFS_SVH

`define RSR_ADDR_STATUS    8'hE9
`define RSR_ADDR_PC        8'hEA
`define RSR_ADDR_BITS      4'h8
`define RSR_FRAME_BITS     56
`define RSR_FRAME_LAST     6'h37
`define RSR_CS_BITS        48
`define RSR_PC_BITS        16
`define RSR_STAT_BITS      8

// status field positions inside the first byte
`define RSR_POS_FLAG       0
`define RSR_POS_ERR        1
`define RSR_POS_DELAY      2
`define RSR_POS_RATE       4
`define RSR_POS_ZERO       7

// channel-status group positions
`define RSR_CS_APP         0
`define RSR_CS_CTRL_LO     1
`define RSR_CS_CTRL_HI     5
`define RSR_CS_CAT_LO      8
`define RSR_CS_CAT_HI      15
`define RSR_CS_SRC_LO      16
`define RSR_CS_SRC_HI      19
`define RSR_CS_CHAN_LO     20
`define RSR_CS_CHAN_HI     23
`define RSR_CS_RATE_LO     24
`define RSR_CS_RATE_HI     27
`define RSR_CS_ACC_LO      28
`define RSR_CS_ACC_HI      29
`define RSR_CS_WLEN_LO     32
`define RSR_CS_WLEN_HI     35

// Pc word field positions
`define RSR_PC_STREAM_LO   13
`define RSR_PC_INFO_LO     8
`define RSR_PC_INFO_HI     12
`define RSR_PC_ERR         7
`define RSR_PC_TYPE_HI     4

`endif

// ### rsr_pkg.sv
// types for the receiver status read-out block
package rsr_pkg;

  typedef enum logic [1:0] {
    RSR_IDLE = 2'b00,
    RSR_READ = 2'b01,
    RSR_SKIP = 2'b10
  } rsr_state_e;

  typedef enum logic [1:0] {
    RSR_SEL_NONE   = 2'b00,
    RSR_SEL_STATUS = 2'b01,
    RSR_SEL_PC     = 2'b10
  } rsr_sel_e;

  typedef logic [5:0] rsr_pos_t;

endpackage

// ### rsr_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module rsr_sync #(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // pins and synchronised levels
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1_ff;
  logic [WIDTH-1:0] stage2_ff;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          stage1_ff[g] <= 1'b0;
          stage2_ff[g] <= 1'b0;
        end else begin
          stage1_ff[g] <= pin_in[g];
          stage2_ff[g] <= stage1_ff[g];
        end
      end
    end
  endgenerate

  assign pin_sync = stage2_ff;

endmodule

// ### rsr_readout.sv
// serial read-out of receiver status, channel status and burst preamble Pc
`timescale 1ns/100ps
`include "rsr_defs.svh"
module rsr_readout (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     nrst,
  // three-wire serial control bus pins
  input  wire logic                     bus_clk,
  input  wire logic                     bus_ce,
  input  wire logic                     bus_di,
  output logic                          bus_do,
  output logic                          bus_do_oe,
  // live status pins from the receiver core
  input  wire logic                     chan_status_update_flag,
  input  wire logic                     error_pin,
  input  wire logic                     delay_state_bit0,
  input  wire logic                     delay_state_bit1,
  input  wire logic                     rate_code_bit0,
  input  wire logic                     rate_code_bit1,
  input  wire logic                     rate_code_bit2,
  // received data from the receiver core
  input  wire logic [`RSR_CS_BITS-1:0]  chan_status_bits,
  input  wire logic [`RSR_PC_BITS-1:0]  pc_word,
  // read activity
  output rsr_pkg::rsr_sel_e             read_sel
);
  import rsr_pkg::*;

  // address decode, shared by the capture path and the read-out select
  function automatic rsr_sel_e decode_addr(input logic [7:0] addr, input logic [3:0] cnt);
    rsr_sel_e sel;
    sel = RSR_SEL_NONE;
    if (cnt == `RSR_ADDR_BITS && addr == `RSR_ADDR_STATUS) begin
      sel = RSR_SEL_STATUS;
    end else if (cnt == `RSR_ADDR_BITS && addr == `RSR_ADDR_PC) begin
      sel = RSR_SEL_PC;
    end
    return sel;
  endfunction

  // pin synchronisation
  logic [2:0] pins_sync;

  rsr_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .pin_in   ({bus_di, bus_ce, bus_clk}),
    .pin_sync (pins_sync)
  );

  wire sclk_s = pins_sync[0];
  wire ce_s   = pins_sync[1];
  wire di_s   = pins_sync[2];

  logic                      sclk_prev_ff;
  logic                      ce_prev_ff;
  rsr_state_e                state_ff;
  rsr_state_e                nxt_state;
  rsr_sel_e                  sel_ff;
  logic [7:0]                addr_ff;
  logic [3:0]                addr_cnt_ff;
  logic [`RSR_FRAME_BITS-1:0] frame_ff;
  rsr_pos_t                  pos_ff;
  logic                      do_ff;

  wire sclk_rise = sclk_s & ~sclk_prev_ff;
  wire sclk_fall = ~sclk_s & sclk_prev_ff;
  wire ce_rise   = ce_s & ~ce_prev_ff;
  wire ce_fall   = ~ce_s & ce_prev_ff;

  // selection taken from the address shifted in while chip enable was low
  wire rsr_sel_e addr_sel = decode_addr(addr_ff, addr_cnt_ff);

  // status byte built from live pins at the start of the read
  wire [`RSR_STAT_BITS-1:0] status_byte;
  assign status_byte[`RSR_POS_FLAG]                 = chan_status_update_flag;
  assign status_byte[`RSR_POS_ERR]                  = error_pin;
  assign status_byte[`RSR_POS_DELAY+1:`RSR_POS_DELAY] = {delay_state_bit1, delay_state_bit0};
  assign status_byte[`RSR_POS_RATE+2:`RSR_POS_RATE]   = {rate_code_bit2, rate_code_bit1,
                                                         rate_code_bit0};
  assign status_byte[`RSR_POS_ZERO]                 = 1'b0;

  // Pc word reversed so bit 15 leaves first from the low end of the frame
  wire [`RSR_PC_BITS-1:0] pc_rev;
  genvar g;
  generate
    for (g = 0; g < `RSR_PC_BITS; g++) begin : g_pc
      assign pc_rev[g] = pc_word[`RSR_PC_BITS-1-g];
    end
  endgenerate

  // frame images, position n in bit n; channel-status bits kept in their own order
  wire [`RSR_FRAME_BITS-1:0] status_frame = {chan_status_bits, status_byte};
  wire [`RSR_FRAME_BITS-1:0] pc_frame     = {{(`RSR_FRAME_BITS-`RSR_PC_BITS){1'b0}}, pc_rev};

  wire [`RSR_FRAME_BITS-1:0] load_frame =
    (addr_sel == RSR_SEL_STATUS) ? status_frame :
    (addr_sel == RSR_SEL_PC)     ? pc_frame     : {`RSR_FRAME_BITS{1'b0}};

  // next state
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RSR_IDLE: begin
        if (ce_rise) begin
          nxt_state = (addr_sel == RSR_SEL_NONE) ? RSR_SKIP : RSR_READ;
        end
      end
      RSR_READ: begin
        if (ce_fall) begin
          nxt_state = RSR_IDLE;
        end
      end
      RSR_SKIP: begin
        if (ce_fall) begin
          nxt_state = RSR_IDLE;
        end
      end
      default: begin
        nxt_state = RSR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_prev_ff <= 1'b0;
      ce_prev_ff   <= 1'b0;
      state_ff     <= RSR_IDLE;
    end else begin
      sclk_prev_ff <= sclk_s;
      ce_prev_ff   <= ce_s;
      state_ff     <= nxt_state;
    end
  end

  // address capture, LSB first on rising bus clock while chip enable is low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      addr_ff     <= 8'h00;
      addr_cnt_ff <= 4'h0;
    end else if (ce_fall) begin
      addr_cnt_ff <= 4'h0;
    end else if (state_ff == RSR_IDLE && !ce_s && sclk_rise) begin
      addr_ff <= {di_s, addr_ff[7:1]};
      if (addr_cnt_ff != 4'hF) begin
        addr_cnt_ff <= addr_cnt_ff + 4'h1;
      end
    end
  end

  // frame snapshot at the start of the read, then one position per bus clock
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_ff <= {`RSR_FRAME_BITS{1'b0}};
      pos_ff   <= 6'h00;
      sel_ff   <= RSR_SEL_NONE;
    end else if (ce_fall) begin
      // a chip enable drop ends the read even on a coinciding bus clock fall
      sel_ff <= RSR_SEL_NONE;
    end else if (state_ff == RSR_IDLE && ce_rise) begin
      frame_ff <= load_frame;
      pos_ff   <= 6'h00;
      sel_ff   <= addr_sel;
    end else if (state_ff == RSR_READ && sclk_fall) begin
      frame_ff <= {1'b0, frame_ff[`RSR_FRAME_BITS-1:1]};
      if (pos_ff != `RSR_FRAME_LAST) begin
        pos_ff <= pos_ff + 6'h01;
      end
    end
  end

  // serial data output register
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      do_ff <= 1'b0;
    end else if (nxt_state == RSR_READ && state_ff == RSR_IDLE) begin
      do_ff <= load_frame[0];
    end else if (nxt_state != RSR_READ) begin
      do_ff <= 1'b0;
    end else if (sclk_fall) begin
      // past the last position the line stays low
      do_ff <= (pos_ff == `RSR_FRAME_LAST) ? 1'b0 : frame_ff[1];
    end
  end

  assign bus_do    = do_ff;
  assign bus_do_oe = (state_ff == RSR_READ);
  assign read_sel  = sel_ff;

endmodule

// ### rsr_readout_checker.sv
// assertions on the read-out ports
`timescale 1ns/100ps
`include "rsr_defs.svh"
module rsr_readout_checker
  import rsr_pkg::*;
(
  // clock and reset
  input wire logic                    core_clk,
  input wire logic                    nrst,
  // serial bus
  input wire logic                    bus_clk,
  input wire logic                    bus_ce,
  input wire logic                    bus_do,
  input wire logic                    bus_do_oe,
  // core side
  input wire logic                    chan_status_update_flag,
  input wire logic [`RSR_PC_BITS-1:0] pc_word,
  input wire rsr_pkg::rsr_sel_e       read_sel
);
  logic [2:0] lo_ff;
  logic [2:0] nxt_lo;
  // core clocks the bus clock pin has been low, saturating
  assign nxt_lo = bus_clk ? 3'h0 : ((lo_ff == 3'h7) ? lo_ff : lo_ff + 3'h1);
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) lo_ff <= 3'h0;
    else lo_ff <= nxt_lo;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_quiet; !bus_do_oe |-> !bus_do; endproperty
  a_quiet: assert property (p_quiet) else $error("data high while idle");
  property p_sel; bus_do_oe == (read_sel != RSR_SEL_NONE); endproperty
  a_sel: assert property (p_sel) else $error("select and enable disagree");
  property p_start; $rose(bus_do_oe) |-> bus_ce && $past(bus_ce, 2); endproperty
  a_start: assert property (p_start) else $error("read began without enable");
  property p_end; $fell(bus_ce) |-> ##[1:6] !bus_do_oe; endproperty
  a_end: assert property (p_end) else $error("read did not end");
  property p_hold; $fell(bus_do_oe) |-> !bus_ce; endproperty
  a_hold: assert property (p_hold) else $error("read ended early");
  property p_pc; $rose(bus_do_oe) && read_sel == RSR_SEL_PC && pc_word == $past(pc_word, 4) |-> bus_do == pc_word[15];
  endproperty
  a_pc: assert property (p_pc) else $error("first Pc position wrong");
  property p_flag; $rose(bus_do_oe) && read_sel == RSR_SEL_STATUS
    && chan_status_update_flag == $past(chan_status_update_flag, 4) |-> bus_do == chan_status_update_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("first status position wrong");
  property p_shift; $changed(bus_do) && bus_do_oe && $past(bus_do_oe) |-> lo_ff >= 3'h2; endproperty
  a_shift: assert property (p_shift) else $error("data moved off the falling edge");
endmodule
bind rsr_readout rsr_readout_checker u_chk (.core_clk, .nrst, .bus_clk, .bus_ce, .bus_do, .bus_do_oe,
  .chan_status_update_flag, .pc_word, .read_sel);

// ### rsr_host_model.sv
// host model driving the serial read-out bus
`timescale 1ns/100ps
module rsr_host_model (
  // alignment clock
  input  wire logic core_clk,
  // serial bus
  output logic      bus_clk,
  output logic      bus_ce,
  output logic      bus_di,
  input  wire logic bus_do,
  input  wire logic bus_do_oe
);
  initial begin
    bus_clk = 1'b0;
    bus_ce  = 1'b0;
    bus_di  = 1'b0;
  end
  // address lsb first, then n positions sampled before each rise
  task automatic xfer(input logic [7:0] adr, input int n, output logic [55:0] q, output logic seen);
    int i;
    q = '0;
    seen = 1'b0;
    @(posedge core_clk);
    #1;
    for (i = 0; i < 8; i++) begin
      bus_di = adr[i];
      #80 bus_clk = 1'b1;
      #80 bus_clk = 1'b0;
    end
    #80 bus_ce = 1'b1;
    bus_di = ~bus_di;
    #100;
    for (i = 0; i < n; i++) begin
      q[i] = bus_do;
      seen = seen | bus_do_oe;
      bus_clk = 1'b1;
      #60 bus_clk = 1'b0;
      #100;
    end
    bus_ce = 1'b0;
    #200;
  endtask
endmodule

// ### rsr_tb.sv
// self-checking bench for the status read-out
`timescale 1ns/100ps
`include "rsr_defs.svh"
module tb;
  import rsr_pkg::*;
  logic        core_clk, nrst, bus_clk, bus_ce, bus_di, bus_do, bus_do_oe, seen;
  logic [6:0]  pins;
  logic [47:0] cs;
  logic [15:0] pc;
  logic [55:0] q, exp;
  rsr_sel_e    rsel;
  int          err_total, n_compared, k, i;
  rsr_readout u_dut (.core_clk, .nrst, .bus_clk, .bus_ce, .bus_di, .bus_do, .bus_do_oe,
    .chan_status_update_flag(pins[0]), .error_pin(pins[1]), .delay_state_bit0(pins[2]),
    .delay_state_bit1(pins[3]), .rate_code_bit0(pins[4]), .rate_code_bit1(pins[5]),
    .rate_code_bit2(pins[6]), .chan_status_bits(cs), .pc_word(pc), .read_sel(rsel));
  rsr_host_model u_host (.core_clk, .bus_clk, .bus_ce, .bus_di, .bus_do, .bus_do_oe);
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input logic [55:0] got, input logic [55:0] want);
    n_compared++;
    if (got !== want) begin
      err_total++;
      $display("unexpected at %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic t_status;
    for (k = 0; k < 2; k++) begin
      pins = 7'h7F;
      repeat (4) @(posedge core_clk);
      #1;
      pins = k ? 7'h54 : 7'h2A;
      cs = k ? 48'h0123456789AB : 48'hFEDCBA987654;
      u_host.xfer(`RSR_ADDR_STATUS, 56, q, seen);
      chk(q, {cs, 1'b0, pins});
      chk(56'(seen), 56'h1);
      chk(56'(rsel), 56'(RSR_SEL_NONE));
    end
    $display("status test done");
  endtask
  task automatic t_freeze;
    pins = 7'h01;
    cs = 48'hA5A50F0F3C3C;
    exp = {cs, 1'b0, pins};
    fork
      u_host.xfer(`RSR_ADDR_STATUS, 56, q, seen);
      begin
        #2000 chk(56'(rsel), 56'(RSR_SEL_STATUS));
        pins = 7'h7E;
        cs = ~cs;
      end
    join
    chk(q, exp);
    $display("freeze test done");
  endtask
  task automatic t_pc;
    for (k = 0; k < 2; k++) begin
      pc = k ? 16'h4D3A : 16'hB2C5;
      exp = '0;
      for (i = 0; i < 16; i++) exp[i] = pc[15-i];
      fork
        u_host.xfer(`RSR_ADDR_PC, 56, q, seen);
        #2000 chk(56'(rsel), 56'(RSR_SEL_PC));
      join
      chk(q, exp);
      chk(56'(seen), 56'h1);
    end
    $display("pc test done");
  endtask
  task automatic t_bad;
    for (k = 0; k < 2; k++) begin
      u_host.xfer(k ? 8'hEB : 8'hE8, 8, q, seen);
      chk({q[54:0], seen}, 56'h0);
    end
    $display("bad address test done");
  endtask
  initial begin
    err_total = 0;
    n_compared = 0;
    nrst = 1'b0;
    pins = 7'h00;
    cs = '0;
    pc = '0;
    repeat (4) @(posedge core_clk);
    #1;
    nrst = 1'b1;
    t_status;
    t_freeze;
    t_pc;
    t_bad;
    results;
  end
  initial begin
    #400000;
    err_total++;
    results;
  end
endmodule
